/* File: core/fwe_pkg.sv */
// Constants, types and opcodes for the flash write-enable and status block
package fwe_pkg;

  // Opcodes
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_REGION_WIPE_A = 8'hD8;
  localparam logic [7:0] CMD_REGION_WIPE_B = 8'h20;
  localparam logic [7:0] CMD_FULL_WIPE_A = 8'hC7;
  localparam logic [7:0] CMD_FULL_WIPE_B = 8'h60;
  localparam logic [7:0] CMD_PAR_ENTER = 8'h55;
  localparam logic [7:0] CMD_PAR_EXIT = 8'h45;

  // Frame lengths in bits
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_STATUS_WR = 6'h10;
  localparam logic [5:0] BITS_ADDR_END = 6'h20;
  localparam logic [5:0] BITS_PROG_MIN = 6'h28;
  localparam logic [5:0] BITS_SAT = 6'h3F;
  localparam logic [2:0] BYTE_EDGE = 3'h0;

  // Status byte layout
  localparam int ST_LOCK = 7;
  localparam int ST_GUARD3 = 5;
  localparam int ST_GUARD_LO = 2;
  localparam int ST_WEL = 1;
  localparam int ST_BUSY = 0;
  localparam int ADDR_W = 24;
  localparam int SEC_MSB = 23;
  localparam int SEC_LSB = 16;
  localparam logic [3:0] GUARD_NONE = 4'h0;
  localparam logic [3:0] GUARD_HALF = 4'h8;
  localparam logic [8:0] SEC_TOTAL = 9'h100;
  localparam logic [8:0] SEC_ONE = 9'h001;

  // Non-volatile defaults at power-up
  localparam logic NV_LOCK_RESET = 1'b0;
  localparam logic [3:0] NV_GUARD_RESET = 4'h0;

  // Pin synchroniser lanes: cs_n, sck, si, wp_n
  localparam int PIN_CS = 3;
  localparam int PIN_SCK = 2;
  localparam int PIN_SI = 1;
  localparam int PIN_WP = 0;
  localparam logic [3:0] PIN_IDLE = 4'h9;

  // Status write duration
  localparam int CLK_MHZ = 125;
  localparam int STATUS_WRITE_NS = 1000;
  localparam int STATUS_WRITE_CYC = (STATUS_WRITE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] WRITE_STATUS_CMD_CYC = 8'(STATUS_WRITE_CYC);
  localparam logic [7:0] TMR_LAST = 8'h01;

  typedef enum logic [1:0] {
    FWE_OP_IDLE = 2'b00,
    FWE_OP_STATUS = 2'b01,
    FWE_OP_ARRAY = 2'b10
  } fwe_op_kind_t;

  typedef struct packed {
    logic [3:0] f1;
    logic [3:0] f2;
    logic [3:0] f3;
    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] fall;
  } fwe_sync_state_t;

  typedef struct packed {
    logic [31:0] sh;
    logic [5:0] cnt;
    logic [2:0] bmod;
    logic [2:0] oidx;
    logic [7:0] op;
    logic [7:0] wdata;
    logic [23:0] addr;
    logic write_latch_bit;
    logic busy;
    fwe_op_kind_t kind;
    logic [7:0] tmr;
    logic lock;
    logic [3:0] guard;
    logic par;
    logic so;
    logic so_oe_n;
    logic [7:0] pout;
    logic pout_oe_n;
    logic prog_go;
    logic region_go;
    logic full_go;
  } fwe_core_state_t;

endpackage

/* File: core/fwe_pins_if.sv */
// Synchronised pin levels and serial clock edges between synchroniser and core
`timescale 1ns/1ps
interface fwe_pins_if;
  logic cs_n;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic si;
  logic wp_n;

  modport drv (output cs_n, output cs_rise, output sck_rise, output sck_fall,
               output si, output wp_n);
  modport use_side (input cs_n, input cs_rise, input sck_rise, input sck_fall,
                    input si, input wp_n);
endinterface

/* File: core/fwe_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module fwe_pin_sync (
  input logic clk,
  input logic rstn,
  input logic [3:0] pins,
  fwe_pins_if.drv pio
);
  import fwe_pkg::*;

  fwe_sync_state_t st;
  fwe_sync_state_t next_st;
  logic [3:0] chg;

  ////////////////////////////////////////////////////////////////////////
  // A lane moves only once stages two and three agree; stage one feeds stage two only
  always_comb begin
    next_st = st;
    chg = ~(st.f2 ^ st.f3) & (st.f3 ^ st.lvl);
    next_st.f1 = pins;
    next_st.f2 = st.f1;
    next_st.f3 = st.f2;
    next_st.lvl = st.lvl ^ chg;
    next_st.rise = chg & st.f3;
    next_st.fall = chg & ~st.f3;
  end

  // Idle levels at reset so no false frame edge appears
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{f1: PIN_IDLE, f2: PIN_IDLE, f3: PIN_IDLE, lvl: PIN_IDLE,
              rise: GUARD_NONE, fall: GUARD_NONE};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Export to the core
  assign pio.cs_n = st.lvl[PIN_CS];
  assign pio.cs_rise = st.rise[PIN_CS];
  assign pio.sck_rise = st.rise[PIN_SCK];
  assign pio.sck_fall = st.fall[PIN_SCK];
  assign pio.si = st.lvl[PIN_SI];
  assign pio.wp_n = st.lvl[PIN_WP];
endmodule

/* File: core/fwe_status_core.sv */
// Write latch, busy flag, status and protection logic of the serial flash
`timescale 1ns/1ps
module fwe_status_core #(
  parameter bit SMALL_SECTOR = 1'b0
) (
  input logic clk,
  input logic rstn,
  input logic chip_select_n,
  input logic serial_clk,
  input logic serial_in,
  input logic protect_accel_pin,
  input logic op_done,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic [7:0] parallel_out_bus,
  output logic parallel_out_oe_n,
  output logic program_go,
  output logic region_wipe_go,
  output logic full_wipe_go,
  output logic [fwe_pkg::ADDR_W-1:0] op_addr
);
  import fwe_pkg::*;

  fwe_pins_if pio ();
  fwe_core_state_t st;
  fwe_core_state_t next_st;
  logic [31:0] sh_in;
  logic [5:0] cnt_in;
  logic hw_locked_mode;
  logic [7:0] stat;
  logic frame_end;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Status byte as seen by the host
  function automatic logic [7:0] status_byte(input logic lock, input logic [3:0] g,
                                             input logic write_latch_bit, input logic busy);
    logic [7:0] b;
    b = 8'h00;
    b[ST_LOCK] = lock;
    b[ST_GUARD3] = SMALL_SECTOR ? g[3] : 1'b0;
    b[ST_GUARD_LO +: 3] = g[2:0];
    b[ST_WEL] = write_latch_bit;
    b[ST_BUSY] = busy;
    return b;
  endfunction

  // Guarded top region: 2^(g-1) 64K sectors, codes past half guard all
  function automatic logic guard_hit(input logic [3:0] g, input logic [23:0] a);
    logic [8:0] lim;
    lim = SEC_TOTAL - (SEC_ONE << (g - 4'h1));
    if (g == GUARD_NONE) begin
      return 1'b0;
    end else if (g > GUARD_HALF) begin
      return 1'b1;
    end else begin
      return {1'b0, a[SEC_MSB:SEC_LSB]} >= lim;
    end
  endfunction

  function automatic logic is_cmd(input logic [7:0] op, input logic [7:0] a,
                                  input logic [7:0] b);
    return (op == a) || (op == b);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pins enter through the synchroniser
  fwe_pin_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .pins({chip_select_n, serial_clk, serial_in, protect_accel_pin}),
    .pio(pio)
  );

  // Lock needs both the bit and a low pin; pin high releases at once
  assign hw_locked_mode = st.lock && !pio.wp_n;
  assign stat = status_byte(st.lock, st.guard, st.write_latch_bit, st.busy);
  assign frame_end = pio.cs_rise;
  assign sh_in = {st.sh[30:0], pio.si};
  assign cnt_in = (st.cnt == BITS_SAT) ? BITS_SAT : 6'(st.cnt + 6'h01);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.prog_go = 1'b0;
    next_st.region_go = 1'b0;
    next_st.full_go = 1'b0;

    // Shift in on rising serial clock while selected
    if (!pio.cs_n && pio.sck_rise) begin
      next_st.sh = sh_in;
      next_st.cnt = cnt_in;
      next_st.bmod = 3'(st.bmod + 3'h1);
      if (cnt_in == BITS_OPCODE) begin
        next_st.op = sh_in[7:0];
      end
      if (cnt_in == BITS_STATUS_WR) begin
        next_st.wdata = sh_in[7:0];
      end
      if (cnt_in == BITS_ADDR_END) begin
        next_st.addr = sh_in[23:0];
      end
    end

    // Drive status on falling edge; live value, so busy changes show up
    if (!pio.cs_n && pio.sck_fall && st.cnt >= BITS_OPCODE
        && st.op == CMD_READ_STATUS) begin
      if (st.par) begin
        next_st.pout = stat;
        next_st.pout_oe_n = 1'b0;
      end else begin
        next_st.so = stat[3'h7 - st.oidx];
        next_st.so_oe_n = 1'b0;
        next_st.oidx = 3'(st.oidx + 3'h1);
      end
    end

    // Internal operation completion clears busy and the latch
    if (st.busy) begin
      if (st.kind == FWE_OP_STATUS) begin
        next_st.tmr = 8'(st.tmr - 8'h01);
        if (st.tmr == TMR_LAST) begin
          next_st.busy = 1'b0;
          next_st.write_latch_bit = 1'b0;
          next_st.kind = FWE_OP_IDLE;
        end
      end else if (op_done) begin
        next_st.busy = 1'b0;
        next_st.write_latch_bit = 1'b0;
        next_st.kind = FWE_OP_IDLE;
      end
    end

    // Frame end: only whole frames act, and nothing but reads while busy
    if (frame_end && !st.busy) begin
      case (st.op)
        CMD_WRITE_ENABLE: begin
          if (st.cnt == BITS_OPCODE) begin
            next_st.write_latch_bit = 1'b1;
          end
        end
        CMD_WRITE_DISABLE: begin
          if (st.cnt == BITS_OPCODE) begin
            next_st.write_latch_bit = 1'b0;
          end
        end
        CMD_WRITE_STATUS: begin
          if (st.cnt == BITS_STATUS_WR && st.write_latch_bit && !hw_locked_mode) begin
            next_st.lock = st.wdata[ST_LOCK];
            next_st.guard = SMALL_SECTOR ? st.wdata[5:2]
                                         : {1'b0, st.wdata[4:2]};
            next_st.busy = 1'b1;
            next_st.kind = FWE_OP_STATUS;
            next_st.tmr = WRITE_STATUS_CMD_CYC;
          end
        end
        CMD_PAGE_PROGRAM: begin
          if (st.cnt >= BITS_PROG_MIN && st.bmod == BYTE_EDGE && st.write_latch_bit
              && !guard_hit(st.guard, st.addr)) begin
            next_st.prog_go = 1'b1;
            next_st.busy = 1'b1;
            next_st.kind = FWE_OP_ARRAY;
          end
        end
        CMD_PAR_ENTER: begin
          if (st.cnt == BITS_OPCODE) begin
            next_st.par = 1'b1;
          end
        end
        CMD_PAR_EXIT: begin
          if (st.cnt == BITS_OPCODE) begin
            next_st.par = 1'b0;
          end
        end
        default: begin
          if (is_cmd(st.op, CMD_REGION_WIPE_A, CMD_REGION_WIPE_B)
              && st.cnt == BITS_ADDR_END && st.write_latch_bit
              && !guard_hit(st.guard, st.addr)) begin
            next_st.region_go = 1'b1;
            next_st.busy = 1'b1;
            next_st.kind = FWE_OP_ARRAY;
          end
          if (is_cmd(st.op, CMD_FULL_WIPE_A, CMD_FULL_WIPE_B)
              && st.cnt == BITS_OPCODE && st.write_latch_bit
              && st.guard == GUARD_NONE) begin
            next_st.full_go = 1'b1;
            next_st.busy = 1'b1;
            next_st.kind = FWE_OP_ARRAY;
          end
        end
      endcase
    end

    // Deselected: restart framing, release outputs
    if (pio.cs_n) begin
      next_st.cnt = 6'h00;
      next_st.bmod = 3'h0;
      next_st.oidx = 3'h0;
      next_st.so_oe_n = 1'b1;
      next_st.pout_oe_n = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; lock and guard take their stored defaults at power-up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.lock <= NV_LOCK_RESET;
      st.guard <= NV_GUARD_RESET;
      st.so_oe_n <= 1'b1;
      st.pout_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign serial_out = st.so;
  assign serial_out_oe_n = st.so_oe_n;
  assign parallel_out_bus = st.pout;
  assign parallel_out_oe_n = st.pout_oe_n;
  assign program_go = st.prog_go;
  assign region_wipe_go = st.region_go;
  assign full_wipe_go = st.full_go;
  assign op_addr = st.addr;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_write_enable_cmd_sets;
    @(posedge clk) disable iff (!rstn)
      frame_end && !st.busy && st.op == CMD_WRITE_ENABLE && st.cnt == BITS_OPCODE
      |=> st.write_latch_bit && !st.busy;
  endproperty
  a_write_enable_cmd_sets: assert property (p_write_enable_cmd_sets) else $error("write enable not latched");

  property p_write_disable_cmd_clears;
    @(posedge clk) disable iff (!rstn)
      frame_end && !st.busy && st.op == CMD_WRITE_DISABLE && st.cnt == BITS_OPCODE
      |=> !st.write_latch_bit;
  endproperty
  a_write_disable_cmd_clears: assert property (p_write_disable_cmd_clears) else $error("write disable ignored");

  property p_short_frame;
    @(posedge clk) disable iff (!rstn)
      frame_end && !st.busy && st.cnt != BITS_OPCODE
      |=> $stable(st.write_latch_bit);
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("partial frame moved latch");

  property p_no_latch_no_write;
    @(posedge clk) disable iff (!rstn)
      frame_end && !st.write_latch_bit && st.op == CMD_WRITE_STATUS
      |=> $stable(st.guard) && $stable(st.lock) && !$rose(st.busy);
  endproperty
  a_no_latch_no_write: assert property (p_no_latch_no_write)
    else $error("status written without latch");

  property p_locked_ignores;
    @(posedge clk) disable iff (!rstn)
      frame_end && hw_locked_mode && st.op == CMD_WRITE_STATUS
      |=> $stable(st.guard) && $stable(st.lock);
  endproperty
  a_locked_ignores: assert property (p_locked_ignores)
    else $error("status changed while locked");

  property p_write_status_cmd_keeps_latch;
    @(posedge clk) disable iff (!rstn)
      $rose(st.busy) && st.kind == FWE_OP_STATUS
      |-> st.write_latch_bit ##1 (st.busy && st.write_latch_bit) [*4];
  endproperty
  a_write_status_cmd_keeps_latch: assert property (p_write_status_cmd_keeps_latch)
    else $error("status write touched latch");

  property p_done_clears;
    @(posedge clk) disable iff (!rstn)
      st.busy && st.kind == FWE_OP_ARRAY && op_done |=> !st.busy && !st.write_latch_bit;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("completion kept latch");

  // Counts cycles of a running status write; a sequence that long would not unroll
  logic [7:0] write_status_cmd_age;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_status_cmd_age <= 8'h00;
    end else begin
      write_status_cmd_age <= (st.busy && st.kind == FWE_OP_STATUS) ? 8'(write_status_cmd_age + 8'h01) : 8'h00;
    end
  end
  property p_write_status_cmd_time;
    @(posedge clk) disable iff (!rstn)
      $fell(st.busy) && $past(st.kind) == FWE_OP_STATUS |-> write_status_cmd_age == WRITE_STATUS_CMD_CYC;
  endproperty
  a_write_status_cmd_time: assert property (p_write_status_cmd_time) else $error("status write length wrong");

  property p_full_guard;
    @(posedge clk) disable iff (!rstn)
      st.full_go |-> st.guard == GUARD_NONE && st.busy;
  endproperty
  a_full_guard: assert property (p_full_guard) else $error("full wipe with guard set");

  property p_region_guard;
    @(posedge clk) disable iff (!rstn)
      (st.prog_go || st.region_go) |-> !guard_hit(st.guard, st.addr);
  endproperty
  a_region_guard: assert property (p_region_guard) else $error("guarded region written");

  property p_serial_status;
    @(posedge clk) disable iff (!rstn)
      !pio.cs_n && pio.sck_fall && !st.par && st.op == CMD_READ_STATUS
      && st.cnt >= BITS_OPCODE
      |=> !st.so_oe_n && st.so == $past(stat[3'h7 - st.oidx]);
  endproperty
  a_serial_status: assert property (p_serial_status) else $error("status bit wrong");

  property p_parallel_status;
    @(posedge clk) disable iff (!rstn)
      !pio.cs_n && pio.sck_fall && st.par && st.op == CMD_READ_STATUS
      && st.cnt >= BITS_OPCODE
      |=> !st.pout_oe_n && st.pout == $past(stat);
  endproperty
  a_parallel_status: assert property (p_parallel_status)
    else $error("parallel status wrong");

  property p_release_on_deselect;
    @(posedge clk) disable iff (!rstn)
      pio.cs_rise |=> st.so_oe_n && st.pout_oe_n;
  endproperty
  a_release_on_deselect: assert property (p_release_on_deselect)
    else $error("output held after deselect");

  property p_no_lock_free;
    @(posedge clk) disable iff (!rstn)
      !st.lock |-> !hw_locked_mode;
  endproperty
  a_no_lock_free: assert property (p_no_lock_free) else $error("locked without lock bit");
endmodule

/* File: sim/fwe_host_model.sv */
// Host controller model that frames serial commands to the status block
`timescale 1ns/1ps
module fwe_host_model (
  output logic chip_select_n,
  output logic serial_clk,
  output logic serial_in,
  input logic serial_out,
  input logic [7:0] parallel_out_bus
);
  // Half of the 125 ns link clock period
  localparam realtime HALF_NS = 62.5;
  logic [7:0] par_byte;

  // Idle pins: deselected, clock standing low
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
    par_byte = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One frame, MSB first; outputs sampled late in the low phase, settled
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = 64'h0000_0000_0000_0000;
    chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = tx[i];
      #(HALF_NS);
      rx = {rx[62:0], serial_out};
      par_byte = parallel_out_bus;
      serial_clk = 1'b1;
      #(HALF_NS);
      serial_clk = 1'b0;
    end
    // Select rises well after the last falling edge so the sync sees it
    #(HALF_NS);
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
    #300;
  endtask
endmodule

/* File: sim/flash_write_enable_status_tb.sv */
// Self-checking testbench for the write latch and status block
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp); end end
module flash_write_enable_status_tb;
  import fwe_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic chip_select_n, serial_clk, serial_in, serial_out, serial_out_oe_n;
  logic protect_accel_pin = 1'b1;
  logic op_done = 1'b0;
  logic [7:0] parallel_out_bus;
  logic parallel_out_oe_n, program_go, region_wipe_go, full_wipe_go;
  logic [23:0] op_addr;
  logic [63:0] rx;
  logic [7:0] s1, s2, d;
  logic [23:0] a;
  int seed = 86;
  int err_total = 0;
  int tests_run = 0;
  int prog_cnt = 0;
  int reg_cnt = 0;
  int full_cnt = 0;
  int so_drive = 0;
  int po_drive = 0;

  always #4 clk = ~clk;

  fwe_status_core dut_u (
    .clk(clk), .rstn(rstn), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .protect_accel_pin(protect_accel_pin), .op_done(op_done),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .parallel_out_bus(parallel_out_bus), .parallel_out_oe_n(parallel_out_oe_n),
    .program_go(program_go), .region_wipe_go(region_wipe_go),
    .full_wipe_go(full_wipe_go), .op_addr(op_addr)
  );

  fwe_host_model host_u (
    .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in),
    .serial_out(serial_out), .parallel_out_bus(parallel_out_bus)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Go pulses and driven cycles are counted so a stuck or doubled pulse shows up
  always @(posedge clk) begin
    if (serial_out_oe_n === 1'b0) so_drive++;
    if (parallel_out_oe_n === 1'b0) po_drive++;
    if (program_go === 1'b1) prog_cnt++;
    if (region_wipe_go === 1'b1) reg_cnt++;
    if (full_wipe_go === 1'b1) full_cnt++;
  end

  // Large-sector status layout
  function automatic logic [7:0] st(input logic lock, input logic [2:0] g, input logic write_latch_bit,
                                    input logic busy);
    return {lock, 2'b00, g, write_latch_bit, busy};
  endfunction

  task automatic cmd(input logic [7:0] op);
    host_u.frame(64'(op), 8, rx);
  endtask

  // Three bytes framed: opcode, then two repeats of the status
  task automatic rd();
    host_u.frame(64'(CMD_READ_STATUS) << 16, 24, rx);
    s1 = rx[15:8];
    s2 = rx[7:0];
  endtask

  // Polls busy under a bound; a hang shows as a later mismatch
  task automatic wait_idle();
    for (int i = 0; i < 20; i++) begin
      rd();
      if (s2[0] === 1'b0) break;
    end
  endtask

  task automatic wr_status(input logic [7:0] v);
    cmd(CMD_WRITE_ENABLE);
    host_u.frame({48'h0000_0000_0000, CMD_WRITE_STATUS, v}, 16, rx);
    wait_idle();
  endtask

  task automatic pulse_done();
    @(posedge clk) #1 op_done = 1'b1;
    @(posedge clk) #1 op_done = 1'b0;
  endtask

  task automatic set_pin(input logic v);
    @(posedge clk) #1 protect_accel_pin = v;
    repeat (8) @(posedge clk);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run of some 150 us
  initial begin
    #700_000;
    err_total++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (8) @(posedge clk);
    rd();
    `CHECK_EQ(s1, 8'h00)
    `CHECK_EQ(s2, s1)
    `CHECK_EQ(serial_out_oe_n, 1'b1)
    `CHECK_EQ(so_drive > 0, 1'b1)
    end_test("reset");
    cmd(CMD_WRITE_ENABLE);
    rd();
    `CHECK_EQ(s1, st(1'b0, 3'h0, 1'b1, 1'b0))
    `CHECK_EQ(s2, s1)
    cmd(CMD_WRITE_DISABLE);
    rd();
    `CHECK_EQ(s1, 8'h00)
    host_u.frame(64'(CMD_WRITE_ENABLE >> 1), 7, rx);
    rd();
    `CHECK_EQ(s1, 8'h00)
    host_u.frame(64'(CMD_WRITE_ENABLE) << 1, 9, rx);
    rd();
    `CHECK_EQ(s1, 8'h00)
    host_u.frame({48'h0000_0000_0000, CMD_WRITE_STATUS, 8'hFF}, 16, rx);
    rd();
    `CHECK_EQ(s1, 8'h00)
    end_test("latch");
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr_status(d);
      `CHECK_EQ(s2, st(d[7], d[4:2], 1'b0, 1'b0))
    end
    end_test("random status writes");
    wr_status(8'h84);
    set_pin(1'b0);
    cmd(CMD_WRITE_ENABLE);
    host_u.frame({48'h0000_0000_0000, CMD_WRITE_STATUS, 8'h00}, 16, rx);
    rd();
    `CHECK_EQ(s1, st(1'b1, 3'h1, 1'b1, 1'b0))
    set_pin(1'b1);
    wr_status(8'h00);
    `CHECK_EQ(s2, 8'h00)
    set_pin(1'b0);
    wr_status(8'h04);
    `CHECK_EQ(s2, st(1'b0, 3'h1, 1'b0, 1'b0))
    set_pin(1'b1);
    end_test("locked mode");
    cmd(CMD_WRITE_ENABLE);
    cmd(CMD_FULL_WIPE_A);
    host_u.frame({24'h00_0000, CMD_PAGE_PROGRAM, 24'hFF_0000, 8'h5A}, 40, rx);
    rd();
    `CHECK_EQ(full_cnt, 0)
    `CHECK_EQ(prog_cnt, 0)
    `CHECK_EQ(s1, st(1'b0, 3'h1, 1'b1, 1'b0))
    a = 24'($random(seed));
    a[23] = 1'b0;
    host_u.frame({24'h00_0000, CMD_PAGE_PROGRAM, a, 8'hA5}, 40, rx);
    rd();
    `CHECK_EQ(prog_cnt, 1)
    `CHECK_EQ(op_addr, a)
    `CHECK_EQ(s2, st(1'b0, 3'h1, 1'b1, 1'b1))
    pulse_done();
    rd();
    `CHECK_EQ(s1, st(1'b0, 3'h1, 1'b0, 1'b0))
    host_u.frame({24'h00_0000, CMD_PAGE_PROGRAM, a, 8'hA5}, 40, rx);
    `CHECK_EQ(prog_cnt, 1)
    cmd(CMD_WRITE_ENABLE);
    host_u.frame({32'h0000_0000, CMD_REGION_WIPE_A, a + 24'h01_0000}, 32, rx);
    `CHECK_EQ(reg_cnt, 1)
    pulse_done();
    wr_status(8'h00);
    cmd(CMD_WRITE_ENABLE);
    cmd(CMD_FULL_WIPE_B);
    rd();
    `CHECK_EQ(full_cnt, 1)
    `CHECK_EQ(s1, st(1'b0, 3'h0, 1'b1, 1'b1))
    pulse_done();
    rd();
    `CHECK_EQ(s1, 8'h00)
    end_test("array guards");
    cmd(CMD_PAR_ENTER);
    cmd(CMD_WRITE_ENABLE);
    host_u.frame(64'(CMD_READ_STATUS) << 8, 16, rx);
    `CHECK_EQ(host_u.par_byte, st(1'b0, 3'h0, 1'b1, 1'b0))
    `CHECK_EQ(po_drive > 0, 1'b1)
    `CHECK_EQ(parallel_out_oe_n, 1'b1)
    cmd(CMD_PAR_EXIT);
    rd();
    `CHECK_EQ(s1, st(1'b0, 3'h0, 1'b1, 1'b0))
    end_test("parallel");
    give_verdict();
  end
endmodule
